// ### hdl/rrm_ctl.sv
`timescale 1ns/1ps
module rrm_ctl (
  input  wire logic                       clk_sys_i,
  input  wire logic                       srst_i,
  rrm_link_if.ctl                         link,
  input  wire logic                       start_i,
  input  wire logic                       hard_i,
  input  wire logic                       cancel_i,
  input  wire logic                       use_wra_i,
  input  wire logic                       ca_training_i,
  input  wire logic [1:0]                 bg_i,
  input  wire logic [1:0]                 ba_i,
  input  wire logic [rrm_pkg::RRM_ROW_W-1:0] row_i,
  input  wire logic [rrm_pkg::RRM_ADDR_W-1:0] mr0_restore_i,
  output logic                            busy_o,
  output logic                            done_o
);
  import rrm_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE, S_ENTRY, S_KEY, S_ACT, S_WR, S_DATA, S_PGM, S_PRE, S_EXIT, S_RESTORE, S_PST
  } rrm_seq_type;
  rrm_seq_type              st;
  logic [RRM_CNT_W-1:0]     cnt;
  logic [1:0]               key_idx;
  logic [4:0]               key_val;
  logic                     hard;

  always_comb begin
    unique case (key_idx)
      2'h0: key_val = RRM_KEY0;
      2'h1: key_val = RRM_KEY1;
      2'h2: key_val = RRM_KEY2;
      2'h3: key_val = RRM_KEY3;
    endcase
  end

  assign busy_o = st != S_IDLE;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st             <= S_IDLE;
      cnt            <= '0;
      key_idx        <= '0;
      hard           <= 1'b0;
      done_o         <= 1'b0;
      link.cmd       <= RRM_CMD_NOP;
      link.mr_sel    <= '0;
      link.bg        <= '0;
      link.ba        <= '0;
      link.addr      <= '0;
      link.dq_ctl    <= '0;
      link.dq_ctl_oe <= 1'b0;
    end else begin
      link.cmd <= RRM_CMD_NOP;
      done_o   <= 1'b0;
      if (cnt != '0) cnt <= cnt - 1'b1;
      unique case (st)
        // No entry during CA training banks precharged, BUS_INVERSION/CRC off first
        S_IDLE: if (start_i && !ca_training_i) begin
          hard        <= hard_i;
          link.cmd    <= RRM_CMD_MRS;
          link.mr_sel <= RRM_MR_FOUR;
          link.addr   <= '0;
          link.addr[hard_i ? RRM_MR4_HARD : RRM_MR4_SOFT] <= 1'b1;
          cnt         <= RRM_CNT_W'(RRM_MOD_CYC);
          key_idx     <= '0;
          st          <= S_KEY;
        end
        S_KEY: if (cnt == '0) begin
          link.cmd    <= RRM_CMD_MRS;
          link.mr_sel <= {1'b0, RRM_MR_ZERO};
          link.bg     <= '0;
          link.ba     <= '0;
          link.addr   <= {6'h00, key_val, RRM_KEY_LOW};
          cnt         <= RRM_CNT_W'(RRM_MOD_CYC);
          key_idx     <= key_idx + 2'h1;
          if (key_idx == 2'h3) st <= S_ACT;
        end
        S_ACT: if (cnt == '0) begin
          link.cmd  <= RRM_CMD_ACT;
          link.bg   <= bg_i;
          link.ba   <= ba_i;
          link.addr <= {1'b0, row_i};
          cnt       <= RRM_CNT_W'(RRM_MOD_CYC);
          st        <= S_WR;
        end
        S_WR: if (cnt == '0) begin
          link.cmd <= (use_wra_i && hard) ? RRM_CMD_WRA : RRM_CMD_WR;
          cnt      <= RRM_CNT_W'(RRM_WL);
          st       <= S_DATA;
        end
        S_DATA: begin
          if (cnt == RRM_CNT_W'(1)) begin
            link.dq_ctl    <= cancel_i ? '1 : '0;
            link.dq_ctl_oe <= 1'b1;
          end
          if (cnt == '0 && link.dq_ctl_oe) begin
            cnt <= RRM_CNT_W'(RRM_DATA_CYC - 1);
            st  <= S_PGM;
          end
        end
        // Only NOP here; refresh omitted, legal in both flows
        S_PGM: begin
          if (cnt == '0 && link.dq_ctl_oe) begin
            link.dq_ctl_oe <= 1'b0;
            cnt <= hard ? RRM_CNT_W'(RRM_PGM_CYC) : RRM_CNT_W'(RRM_MOD_CYC);
          end else if (cnt == '0) begin
            st <= S_PRE;
          end
        end
        S_PRE: begin
          link.cmd <= RRM_CMD_PRE;
          cnt      <= RRM_CNT_W'(RRM_EXIT_CYC);
          st       <= S_EXIT;
        end
        // Clearing the entry bit also ends an aborted attempt
        // Nothing but NOPs until the new address has settled
        S_EXIT: if (cnt == '0) begin
          link.cmd    <= RRM_CMD_MRS;
          link.mr_sel <= RRM_MR_FOUR;
          link.addr   <= '0;
          cnt         <= RRM_CNT_W'(RRM_PST_CYC);
          st          <= S_RESTORE;
        end
        S_RESTORE: if (cnt == '0) begin
          link.cmd    <= RRM_CMD_MRS;
          link.mr_sel <= {1'b0, RRM_MR_ZERO};
          link.addr   <= mr0_restore_i;
          cnt         <= RRM_CNT_W'(RRM_MOD_CYC);
          st          <= S_PST;
        end
        S_PST: if (cnt == '0) begin
          done_o <= 1'b1; // User may now verify by readback
          st     <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
  // CRC, MULTIPURPOSE_READOUT_REGISTER write and PER_DEVICE_ADDRESSING are never issued by this sequencer
endmodule : rrm_ctl

// ### hdl/rrm_link_if.sv
`timescale 1ns/1ps
interface rrm_link_if;
  import rrm_pkg::*;
  rrm_cmd_type                   cmd;
  logic [2:0]                    mr_sel;
  logic [1:0]                    bg;
  logic [1:0]                    ba;
  logic [rrm_pkg::RRM_ADDR_W-1:0] addr;
  logic [rrm_pkg::RRM_DQ_W-1:0]  dq_ctl;
  logic [rrm_pkg::RRM_DQ_W-1:0]  dq_mem;
  logic                          dq_ctl_oe;
  logic                          dq_mem_oe;
  logic [rrm_pkg::RRM_DQ_W-1:0]  dq;
  assign dq = dq_ctl_oe ? dq_ctl : (dq_mem_oe ? dq_mem : '1);
  modport mem (input cmd, mr_sel, bg, ba, addr, dq, output dq_mem, dq_mem_oe);
  modport ctl (output cmd, mr_sel, bg, ba, addr, dq_ctl, dq_ctl_oe, input dq);
endinterface : rrm_link_if

// ### hdl/rrm_mem.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module rrm_mem (
  input  wire logic                          clk_sys_i,
  input  wire logic                          srst_i,
  rrm_link_if.mem                            link,
  input  wire logic                          crc_en_i,
  input  wire logic                          mask_en_i,
  input  wire logic                          crc_err_lo_i,
  input  wire logic                          crc_err_hi_i,
  input  wire logic                          mask_all_i,
  output logic [rrm_pkg::RRM_DQ_W-1:0]       lane_block_o,
  output logic [7:0]                         mpr_page2_o,
  output logic [rrm_pkg::RRM_NUM_BG-1:0]     hard_used_o,
  output logic [rrm_pkg::RRM_NUM_BG-1:0]     soft_used_o,
  output logic [rrm_pkg::RRM_ROW_W-1:0]      last_row_o,
  output logic                               armed_o
);
  import rrm_pkg::*;
  typedef enum logic [2:0] {K_IDLE, K_1, K_2, K_3, K_ARMED} rrm_key_type;
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_DATA} rrm_dat_type;
  rrm_key_type              key_st;
  rrm_dat_type              dat_st;
  logic                     hard_mode;
  logic                     soft_mode;
  logic                     key_hit;
  logic [4:0]               key_want;
  logic                     tgt_bg;
  logic [RRM_ROW_W-1:0]     tgt_row;
  logic [3:0]               cyc;
  logic                     all_low;
  logic                     cancel;
  logic                     is_mr4;
  logic                     wr_cmd;
  logic                     last_beat;

  assign is_mr4 = link.cmd == RRM_CMD_MRS && link.mr_sel == RRM_MR_FOUR;
  assign wr_cmd    = link.cmd == RRM_CMD_WR || link.cmd == RRM_CMD_WRA;
  assign last_beat = dat_st == D_DATA && cyc == RRM_DATA_CYC[3:0] - 4'h1;
  // Data pins are input-only here; readout travels on mpr_page2_o
  assign link.dq_mem    = '0;
  assign link.dq_mem_oe = 1'b0;

  // Each MR4 write sets both modes, so clearing a bit ends that attempt
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hard_mode <= 1'b0;
      soft_mode <= 1'b0;
    end else if (is_mr4) begin
      hard_mode <= link.addr[RRM_MR4_HARD];
      soft_mode <= link.addr[RRM_MR4_SOFT];
    end
  end

  always_comb begin
    unique case (key_st)
      K_IDLE:  key_want = RRM_KEY0;
      K_1:     key_want = RRM_KEY1;
      K_2:     key_want = RRM_KEY2;
      K_3:     key_want = RRM_KEY3;
      K_ARMED: key_want = RRM_KEY3;
      default: key_want = RRM_KEY0;
    endcase
  end

  // Bank group and bank must both be zero on every key write
  assign key_hit = link.cmd == RRM_CMD_MRS && link.mr_sel == {1'b0, RRM_MR_ZERO}
                 && link.bg == 2'h0 && link.ba == 2'h0
                 && link.addr[RRM_KEY_LSB-1:0] == RRM_KEY_LOW
                 && link.addr[RRM_KEY_MSB:RRM_KEY_LSB] == key_want;

  // Any foreign command before arming drops to idle quietly; no error output exists
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !(hard_mode || soft_mode)) begin
      key_st <= K_IDLE;
    end else if (key_st != K_ARMED && link.cmd != RRM_CMD_NOP) begin
      if (key_hit) begin
        unique case (key_st)
          K_IDLE:  key_st <= K_1;
          K_1:     key_st <= K_2;
          K_2:     key_st <= K_3;
          default: key_st <= K_ARMED;
        endcase
      end else begin
        key_st <= K_IDLE;
      end
    end else if (key_st == K_ARMED && last_beat) begin
      key_st <= K_IDLE;
    end
  end
  assign armed_o = key_st == K_ARMED;

  // ACT captures the row; the write's column is ignored
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tgt_bg  <= 1'b0;
      tgt_row <= '0;
    end else if (armed_o && link.cmd == RRM_CMD_ACT) begin
      tgt_bg  <= link.bg[0];
      tgt_row <= link.addr[RRM_ROW_W-1:0];
    end
  end

  assign all_low = link.dq == '0;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dat_st <= D_IDLE;
      cyc    <= '0;
      cancel <= 1'b0;
    end else begin
      unique case (dat_st)
        D_IDLE: if (armed_o && wr_cmd) begin
          dat_st <= D_WAIT;
          cyc    <= '0;
          cancel <= 1'b0;
        end
        D_WAIT: begin
          cyc <= cyc + 4'h1;
          if (cyc == RRM_WL[3:0] - 4'h1) begin
            dat_st <= D_DATA;
            cyc    <= '0;
          end
        end
        D_DATA: begin
          cyc <= cyc + 4'h1;
          // High on all DQ in first two beats cancels
          if (cyc < RRM_CANCEL_CYC[3:0] && link.dq == '1) cancel <= 1'b1;
          // Mixed patterns are undefined; treat them as a cancel
          if (!all_low) cancel <= 1'b1;
          if (last_beat) dat_st <= D_IDLE;
        end
        default: dat_st <= D_IDLE;
      endcase
    end
  end

  logic commit;
  assign commit = last_beat && !cancel && all_low;
  // Fuse cells ignore srst_i; only power-up finds them unblown
  logic [RRM_NUM_BG-1:0] fuse_blown = '0;
  always_ff @(posedge clk_sys_i) begin
    if (commit && hard_mode && !fuse_blown[tgt_bg]) begin
      fuse_blown[tgt_bg] <= 1'b1;
    end
  end
  assign hard_used_o = fuse_blown;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      soft_used_o <= '0;
      last_row_o  <= '0;
    end else if (commit) begin
      last_row_o <= tgt_row;
      if (soft_mode && !hard_used_o[tgt_bg]) soft_used_o[tgt_bg] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mpr_page2_o <= 8'h00;
    end else begin
      mpr_page2_o               <= 8'h00;
      mpr_page2_o[RRM_MPR_HARD] <= 1'b1;
      mpr_page2_o[RRM_MPR_SOFT] <= 1'b1;
    end
  end

  // Each byte lane is masked on its own error; mask_all_i widens any lane error to the whole word
  logic mask_on;
  logic blk_lo;
  logic blk_hi;
  assign mask_on = crc_en_i && mask_en_i;
  assign blk_lo  = crc_err_lo_i || (mask_all_i && crc_err_hi_i);
  assign blk_hi  = crc_err_hi_i || (mask_all_i && crc_err_lo_i);
  // Mask and CRC both on: failing lanes never reach the array
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lane_block_o <= '0;
    end else if (mask_on) begin
      lane_block_o[7:0]  <= {8{blk_lo}};
      lane_block_o[15:8] <= {8{blk_hi}};
    end else begin
      lane_block_o <= '0;
    end
  end
endmodule : rrm_mem

// ### hdl/rrm_pkg.sv
package rrm_pkg;
  // Command encoding on the shared command bus
  typedef enum logic [2:0] {
    RRM_CMD_NOP  = 3'h0,
    RRM_CMD_MRS  = 3'h1,
    RRM_CMD_ACT  = 3'h2,
    RRM_CMD_WR   = 3'h3,
    RRM_CMD_WRA  = 3'h4,
    RRM_CMD_PRE  = 3'h5,
    RRM_CMD_REF  = 3'h6,
    RRM_CMD_RD   = 3'h7
  } rrm_cmd_type;

  localparam int          RRM_DQ_W        = 16;
  localparam int          RRM_ADDR_W      = 18;
  localparam int          RRM_ROW_W       = 17;
  localparam int          RRM_NUM_BG      = 2;
  localparam logic [1:0]  RRM_MR_ZERO     = 2'h0;
  localparam logic [2:0]  RRM_MR_FOUR     = 3'h4;
  localparam int          RRM_MR4_HARD    = 13;
  localparam int          RRM_MR4_SOFT    = 5;
  localparam int          RRM_MPR_HARD    = 7;
  localparam int          RRM_MPR_SOFT    = 6;
  // Guard key fields A11..A7 in order, A6..A0 fixed
  localparam logic [4:0]  RRM_KEY0        = 5'h19;
  localparam logic [4:0]  RRM_KEY1        = 5'h0F;
  localparam logic [4:0]  RRM_KEY2        = 5'h17;
  localparam logic [4:0]  RRM_KEY3        = 5'h07;
  localparam logic [6:0]  RRM_KEY_LOW     = 7'h7F;
  localparam int          RRM_KEY_LSB     = 7;
  localparam int          RRM_KEY_MSB     = 11;
  localparam int          RRM_WL          = 4;
  localparam int          RRM_DATA_CYC    = 4;
  localparam int          RRM_CANCEL_CYC  = 2;
  localparam int          RRM_CLK_NS      = 20;
  localparam longint      RRM_PGM_MS      = 2000;
  localparam int          RRM_EXIT_NS     = 15;
  localparam int          RRM_PST_US      = 50;
  localparam int          RRM_MOD_CYC     = 24;
  localparam longint      RRM_PGM_CYC     = RRM_PGM_MS * 1000000 / RRM_CLK_NS;
  localparam int          RRM_EXIT_CYC    = (RRM_EXIT_NS + RRM_CLK_NS - 1) / RRM_CLK_NS;
  localparam int          RRM_PST_CYC     = RRM_PST_US * 1000 / RRM_CLK_NS;
  localparam int          RRM_CNT_W       = 27;
endpackage : rrm_pkg

// ### verification/rrm_link_props.sv
`timescale 1ns/1ps
module rrm_link_props
  import rrm_pkg::*;
(
  input wire logic                         clk_sys_i,
  input wire logic                         srst_i,
  input wire rrm_pkg::rrm_cmd_type         cmd,
  input wire logic [2:0]                   mr_sel,
  input wire logic [rrm_pkg::RRM_ADDR_W-1:0] addr,
  input wire logic [rrm_pkg::RRM_DQ_W-1:0] dq,
  input wire logic                         dq_ctl_oe,
  input wire logic                         dq_mem_oe
);
  logic hard_q;
  wire logic mr0 = cmd == RRM_CMD_MRS && mr_sel == 3'h0;
  wire logic mr4 = cmd == RRM_CMD_MRS && mr_sel == RRM_MR_FOUR;
  wire logic k0 = mr0 && addr[11:7] == RRM_KEY0;
  wire logic k1 = mr0 && addr[11:7] == RRM_KEY1;
  wire logic k2 = mr0 && addr[11:7] == RRM_KEY2;
  wire logic k3 = mr0 && addr[11:7] == RRM_KEY3;
  wire logic wr = cmd == RRM_CMD_WR || cmd == RRM_CMD_WRA;
  // Soft flow may precharge early, so quiet time is judged for hard only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) hard_q <= 1'b0;
    else if (mr4) hard_q <= addr[RRM_MR4_HARD];
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  a_mem_quiet: assert property (!dq_mem_oe)
    else $error("memory end drove data");
  a_entry_key: assert property (mr4 && (addr[13] || addr[5]) |=>
    (cmd == RRM_CMD_NOP)[*8] ##[1:40] k0) else $error("entry not followed by key");
  a_key_one: assert property (k0 |-> ##[1:40] k1)
    else $error("second key missing");
  a_key_two: assert property (k1 |-> ##[1:40] k2)
    else $error("third key missing");
  a_key_three: assert property (k2 |-> ##[1:40] k3)
    else $error("fourth key missing");
  a_write_act: assert property (wr |-> $past(cmd, 25) == RRM_CMD_ACT)
    else $error("write not preceded by activate");
  a_data_beats: assert property ($rose(dq_ctl_oe) |->
    (dq == 16'h0000)[*4] or (dq == 16'hFFFF)[*2]) else $error("bad repair data");
  a_no_refresh: assert property (cmd != RRM_CMD_REF)
    else $error("refresh issued");
  a_prog_quiet: assert property ($fell(dq_ctl_oe) && hard_q |->
    (cmd == RRM_CMD_NOP)[*8]) else $error("command during programming");
endmodule : rrm_link_props

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rrm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0, hard = 1'b0, cncl = 1'b0, wra = 1'b0, ca = 1'b0;
  logic        crc = 1'b0, msk = 1'b0, elo = 1'b0, ehi = 1'b0, mall = 1'b0;
  logic [1:0]  bgs = 2'h0, bas = 2'h0, hu, su, hu2;
  logic [16:0] row = 17'h00000, lr;
  logic [17:0] mr0r = 18'h00000;
  logic [15:0] blk;
  logic [7:0]  multipurpose_readout_register, mpr2;
  logic        arm, arm2, busy, done;
  logic [31:0] st = 32'h0000004E;
  int          miscompares = 0, n_checks = 0;
  localparam logic [4:0] KT [4] = '{RRM_KEY0, RRM_KEY1, RRM_KEY2, RRM_KEY3};
  rrm_link_if rrm_link_if_inst ();
  rrm_link_if rrm_link_if_inst2 ();
  rrm_ctl rrm_ctl_inst (.clk_sys_i(clk_sys_i), .srst_i(srst), .link(rrm_link_if_inst.ctl),
    .start_i(start), .hard_i(hard), .cancel_i(cncl), .use_wra_i(wra), .ca_training_i(ca),
    .bg_i(bgs), .ba_i(bas), .row_i(row), .mr0_restore_i(mr0r), .busy_o(busy), .done_o(done));
  rrm_mem rrm_mem_inst (.clk_sys_i(clk_sys_i), .srst_i(srst), .link(rrm_link_if_inst.mem),
    .crc_en_i(crc), .mask_en_i(msk), .crc_err_lo_i(elo), .crc_err_hi_i(ehi), .mask_all_i(mall),
    .lane_block_o(blk), .mpr_page2_o(multipurpose_readout_register), .hard_used_o(hu), .soft_used_o(su),
    .last_row_o(lr), .armed_o(arm));
  // Second memory faces the bench, which breaks the key on purpose
  rrm_mem rrm_mem_inst2 (.clk_sys_i(clk_sys_i), .srst_i(srst), .link(rrm_link_if_inst2.mem),
    .crc_en_i(crc), .mask_en_i(msk), .crc_err_lo_i(elo), .crc_err_hi_i(ehi), .mask_all_i(mall),
    .lane_block_o(), .mpr_page2_o(mpr2), .hard_used_o(hu2), .soft_used_o(),
    .last_row_o(), .armed_o(arm2));
  rrm_link_props rrm_link_props_inst (.clk_sys_i(clk_sys_i), .srst_i(srst),
    .cmd(rrm_link_if_inst.cmd), .mr_sel(rrm_link_if_inst.mr_sel), .addr(rrm_link_if_inst.addr),
    .dq(rrm_link_if_inst.dq), .dq_ctl_oe(rrm_link_if_inst.dq_ctl_oe),
    .dq_mem_oe(rrm_link_if_inst.dq_mem_oe));
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  // v holds crc, mask, low error, high error
  function automatic logic [15:0] exp_blk(input logic [3:0] v, input logic all);
    if (!(v[3] && v[2])) return 16'h0000;
    if (all) return {16{v[1] | v[0]}};
    return {{8{v[0]}}, {8{v[1]}}};
  endfunction : exp_blk
  function automatic logic [17:0] ka(input int k);
    return {6'h00, KT[k], RRM_KEY_LOW};
  endfunction : ka
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A NOP follows every command so no signal is driven twice in one step
  task automatic c2(input rrm_cmd_type c, input logic [17:0] a, input logic [2:0] s);
    rrm_link_if_inst2.cmd <= c;
    rrm_link_if_inst2.mr_sel <= s;
    rrm_link_if_inst2.addr <= a;
    @(posedge clk_sys_i) rrm_link_if_inst2.cmd <= RRM_CMD_NOP;
    @(posedge clk_sys_i);
  endtask : c2
  task automatic ks(input logic [7:0] o, input int a, input int b);
    for (int k = a; k < b; k++) c2(RRM_CMD_MRS, ka(int'(o[2*k +: 2])), 3'h0);
  endtask : ks
  task automatic dq2(input logic [15:0] v);
    rrm_link_if_inst2.dq_ctl_oe <= 1'b1;
    rrm_link_if_inst2.dq_ctl <= v;
    repeat (10) @(posedge clk_sys_i);
    rrm_link_if_inst2.dq_ctl_oe <= 1'b0;
  endtask : dq2
  task automatic wt(input logic v);
    int i;
    for (i = 0; i < 500 && rrm_link_if_inst.dq_ctl_oe !== v; i++) @(posedge clk_sys_i);
    if (i == 500) miscompares++;
  endtask : wt
  task automatic run(input logic h, c, w, input logic [1:0] g, eh, es);
    logic [16:0] r;
    int i;
    r = 17'(rnd());
    @(posedge clk_sys_i);
    {ca, hard, cncl, wra, bgs} <= {1'b0, h, c, w, g};
    {row, bas, mr0r} <= {r, 2'(rnd()), 18'(rnd()) & 18'h3F07F};
    start <= 1'b1;
    @(posedge clk_sys_i) start <= 1'b0;
    #1 chk("busy_run", 32'h1, 32'(busy));
    wt(1'b1);
    wt(1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk("soft_used", 32'(es), 32'(su));
    chk("hard_used", 32'(eh), 32'(hu));
    if (es != 2'h0) chk("last_row", 32'(r), 32'(lr));
    if (!h) begin
      for (i = 0; i < 3000 && done !== 1'b1; i++) begin
        @(posedge clk_sys_i);
        #1;
      end
      chk("done", 32'h1, 32'(done));
    end
    @(posedge clk_sys_i) srst <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst <= 1'b0;
    #1 chk("hard_kept", 32'(eh), 32'(hu));
  endtask : run
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    miscompares++;
    report_and_stop();
  end
  initial begin
    logic [31:0] x;
    rrm_link_if_inst2.cmd = RRM_CMD_NOP;
    rrm_link_if_inst2.mr_sel = 3'h0;
    rrm_link_if_inst2.bg = 2'h0;
    rrm_link_if_inst2.ba = 2'h0;
    rrm_link_if_inst2.addr = 18'h00000;
    rrm_link_if_inst2.dq_ctl = 16'h0000;
    rrm_link_if_inst2.dq_ctl_oe = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    srst <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk("mpr_page2", 32'h000000C0, 32'(multipurpose_readout_register));
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      x = rnd();
      {crc, msk, elo, ehi} <= 4'(i);
      mall <= x[0];
      @(posedge clk_sys_i);
      #1 chk("lane_block", 32'(exp_blk(4'(i), x[0])), 32'(blk));
    end
    @(posedge clk_sys_i);
    c2(RRM_CMD_MRS, 18'h02000, 3'h4);
    ks(8'hE1, 0, 4);
    #1 chk("armed_swapped", 32'h0, 32'(arm2));
    @(posedge clk_sys_i);
    c2(RRM_CMD_MRS, 18'h00000, 3'h4);
    c2(RRM_CMD_MRS, 18'h02000, 3'h4);
    ks(8'hE4, 0, 2);
    c2(RRM_CMD_ACT, 18'(rnd()), 3'h0);
    ks(8'hE4, 2, 4);
    #1 chk("armed_broken", 32'h0, 32'(arm2));
    @(posedge clk_sys_i);
    c2(RRM_CMD_WR, 18'h00000, 3'h0);
    dq2(16'h0000);
    #1 chk("hard_used_b", 32'h0, 32'(hu2));
    chk("mpr_page2_b", 32'h000000C0, 32'(mpr2));
    @(posedge clk_sys_i);
    c2(RRM_CMD_MRS, 18'h00000, 3'h4);
    c2(RRM_CMD_MRS, 18'h02000, 3'h4);
    ks(8'hE4, 0, 4);
    #1 chk("armed", 32'h1, 32'(arm2));
    @(posedge clk_sys_i);
    c2(RRM_CMD_ACT, 18'(rnd()), 3'h0);
    c2(RRM_CMD_WR, 18'h00000, 3'h0);
    dq2(16'h0000);
    #1 chk("hard_used_b", 32'h1, 32'(hu2));
    @(posedge clk_sys_i);
    ca <= 1'b1;
    start <= 1'b1;
    @(posedge clk_sys_i) start <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk("busy_training", 32'h0, 32'(busy));
    run(1'b0, 1'b1, 1'b0, 2'h1, 2'h0, 2'h0);
    run(1'b0, 1'b0, 1'b0, 2'h1, 2'h0, 2'h2);
    run(1'b1, 1'b0, 1'b1, 2'h0, 2'h1, 2'h0);
    run(1'b0, 1'b0, 1'b0, 2'h0, 2'h1, 2'h0);
    run(1'b1, 1'b0, 1'b0, 2'h0, 2'h1, 2'h0);
    run(1'b1, 1'b0, 1'b0, 2'h1, 2'h3, 2'h0);
    report_and_stop();
  end
endmodule : testbench
